/* File: logic/shu_unit.sv */
// Shifter bit-field unit: shift-or, rotate, bit ops, field deposit and flags
// Behaviour
// - Shift-or: arithmetic shift source, OR into destination field, write back.
// - Shift amounts are signed; positive left, negative right; immediate -128..127.
// - Every written result has its low eight extension bits zero.
// - Shift-or flags: zero on zero shifted value, overflow on left shift, sign clear.
// - Rotate the 32-bit source left for positive, right for negative amounts.
// - Rotate flags: zero on zero result, overflow and sign cleared.
// - Bit clear copies source with the chosen bit forced low.
// - Bit set copies source with the chosen bit forced high.
// - Bit toggle copies source with the chosen bit inverted.
// - Positions outside 0..31 leave the operand unchanged for clear, set, toggle.
// - Bit op flags: zero on zero output, overflow above 31, sign clear.
// - Bit test writes nothing; zero when bit low or out of range.
// - Deposit places right-aligned field at position, zeroing bits around it.
// - Position and length are six bits each, 0..63.
// - Deposit flags: overflow when length plus position above 32, zero, sign clear.
// - Deposit-or merges the placed field into the old destination value.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module shu_unit
    import shu_pkg::*;
#(
    parameter int unsigned FIELD_W = FIX_W
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic OP_VALID,
    input wire logic [2:0] OP_CODE,
    input wire logic USE_IMM,
    input wire logic [WORD_W-1:0] SOURCE_REGISTER,
    input wire logic [WORD_W-1:0] DESTINATION_REGISTER,
    input wire logic [WORD_W-1:0] CONTROL_REGISTER_OPERAND,
    input wire logic [IMM_W-1:0] IMMEDIATE_SHIFT_AMOUNT,
    input wire logic [CTL6_W-1:0] FIELD_POSITION_CONTROL,
    input wire logic [CTL6_W-1:0] FIELD_LENGTH_CONTROL,
    input wire logic [REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic [WORD_W-1:0] RESULT_WORD,
    output logic RESULT_WRITE,
    output logic FLAG_UPDATE,
    output logic SHIFTER_ZERO_FLAG,
    output logic SHIFTER_OVERFLOW_FLAG,
    output logic SHIFTER_SIGN_FLAG
);

    // The datapath is built for exactly one 32-bit fixed-point field
    if (FIELD_W != FIX_W)
    begin : g_width_check
        $error("shu_unit supports only a 32-bit fixed-point field");
    end

    shu_op_t op;
    shu_bitmode_t bit_mode;
    logic issue, ctrl_enable_q, shift_left, bit_tested, bit_oor, bit_above, dep_ovf;
    logic res_write, res_zero, res_ovf;
    logic [COUNT_W-1:0] op_count_q;
    logic [FIX_W-1:0] fix_src, fix_dst, fix_ctl, shift_res;
    logic [FIX_W-1:0] bit_res, len_mask, dep_placed, res_fix;
    logic signed [FIX_W-1:0] amount;
    logic [CTL6_W-1:0] dep_len, dep_pos;
    logic [FIX_W+63:0] dep_wide;
    logic [CTL6_W:0] dep_sum;

    assign op = shu_op_t'(OP_CODE);
    assign issue = OP_VALID && ctrl_enable_q;
    // Fixed-point fields sit above the extension byte
    assign fix_src = SOURCE_REGISTER[WORD_W-1:FIX_LSB];
    assign fix_dst = DESTINATION_REGISTER[WORD_W-1:FIX_LSB];
    assign fix_ctl = CONTROL_REGISTER_OPERAND[WORD_W-1:FIX_LSB];
    // Immediate is sign-extended so -128..127 reach the same shifter
    assign amount = USE_IMM ? {{(FIX_W-IMM_W){IMMEDIATE_SHIFT_AMOUNT[IMM_W-1]}},
        IMMEDIATE_SHIFT_AMOUNT} : fix_ctl;

    shu_barrel u_barrel (
        .data(fix_src),
        .amount(amount),
        .rotate(op == OP_ROTATE),
        .result(shift_res),
        .shifted_left(shift_left)
    );

    always_comb
    begin
        case (op)
            OP_BIT_CLEAR: bit_mode = BIT_CLEAR;
            OP_BIT_SET: bit_mode = BIT_SET;
            OP_BIT_TOGGLE: bit_mode = BIT_TOGGLE;
            default: bit_mode = BIT_TEST;
        endcase
    end

    shu_bitop u_bitop (
        .data(fix_src),
        .position(amount),
        .mode(bit_mode),
        .result(bit_res),
        .tested_bit(bit_tested),
        .out_of_range(bit_oor),
        .above_range(bit_above)
    );
    // Field deposit; bits pushed past bit 31 are simply lost off-scale
    assign dep_len = USE_IMM ? FIELD_LENGTH_CONTROL : fix_ctl[CTL_LEN_LSB +: CTL6_W];
    assign dep_pos = USE_IMM ? FIELD_POSITION_CONTROL : fix_ctl[CTL_POS_LSB +: CTL6_W];
    assign len_mask = (dep_len >= CTL6_W'(FIX_W)) ? {FIX_W{1'b1}} :
        ((32'h0000_0001 << dep_len[4:0]) - 32'h0000_0001);
    assign dep_wide = {64'h0, fix_src & len_mask} << dep_pos;
    assign dep_placed = dep_wide[FIX_W-1:0];
    assign dep_sum = {1'b0, dep_len} + {1'b0, dep_pos};
    assign dep_ovf = dep_sum > DEPOSIT_LIMIT;

    always_comb
    begin
        res_fix = 32'h0000_0000;
        res_write = 1'b1;
        res_zero = 1'b0;
        res_ovf = 1'b0;
        case (op)
            OP_ARITH_SHIFT_OR:
            begin
                res_fix = fix_dst | shift_res;
                res_zero = (shift_res == 32'h0000_0000);
                res_ovf = shift_left;
            end
            OP_ROTATE:
            begin
                res_fix = shift_res;
                res_zero = (shift_res == 32'h0000_0000);
            end
            OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE:
            begin
                res_fix = bit_res;
                res_zero = (bit_res == 32'h0000_0000);
                res_ovf = bit_above;
            end
            OP_BIT_TEST:
            begin
                res_write = 1'b0;
                res_zero = !bit_tested || bit_oor;
                res_ovf = bit_above;
            end
            OP_FIELD_DEPOSIT:
            begin
                res_fix = dep_placed;
                res_zero = (dep_placed == 32'h0000_0000);
                res_ovf = dep_ovf;
            end
            OP_FIELD_DEPOSIT_OR:
            begin
                res_fix = fix_dst | dep_placed;
                res_zero = ((fix_dst | dep_placed) == 32'h0000_0000);
                res_ovf = dep_ovf;
            end
            default: res_write = 1'b0;
        endcase
    end
    // Result word and write strobe
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RESULT_WORD <= 40'h00_0000_0000;
            RESULT_WRITE <= 1'b0;
        end
        else
        begin
            RESULT_WRITE <= issue && res_write;
            if (issue && res_write)
            begin
                RESULT_WORD <= {res_fix, EXT_CLEARED};
            end
        end
    end
    // Shifter status flags; held until the next accepted operation
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            FLAG_UPDATE <= 1'b0;
            SHIFTER_ZERO_FLAG <= 1'b0;
            SHIFTER_OVERFLOW_FLAG <= 1'b0;
            SHIFTER_SIGN_FLAG <= 1'b0;
        end
        else
        begin
            FLAG_UPDATE <= issue;
            if (issue)
            begin
                SHIFTER_ZERO_FLAG <= res_zero;
                SHIFTER_OVERFLOW_FLAG <= res_ovf;
                SHIFTER_SIGN_FLAG <= 1'b0;
            end
        end
    end
    // Control register: disabling drops operations without touching state
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_enable_q <= CTRL_ENABLE_RESET;
        end
        else if (REG_WR && REG_ADDR == REG_CTRL_OFS)
        begin
            ctrl_enable_q <= REG_WDATA[CTRL_ENABLE_BIT];
        end
    end
    // Accepted-operation counter, wraps; write clears it
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            op_count_q <= 16'h0000;
        end
        else if (REG_WR && REG_ADDR == REG_COUNT_OFS)
        begin
            op_count_q <= 16'h0000;
        end
        else if (issue)
        begin
            op_count_q <= op_count_q + 16'h0001;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            REG_RDATA <= REG_READ_ZERO;
        end
        else if (REG_RD)
        begin
            case (REG_ADDR)
                REG_CTRL_OFS: REG_RDATA <= {31'h0000_0000, ctrl_enable_q};
                REG_STATUS_OFS: REG_RDATA <= {29'h0000_0000, SHIFTER_SIGN_FLAG,
                    SHIFTER_OVERFLOW_FLAG, SHIFTER_ZERO_FLAG};
                REG_COUNT_OFS: REG_RDATA <= {16'h0000, op_count_q};
                default: REG_RDATA <= REG_READ_ZERO;
            endcase
        end
        else
        begin
            REG_RDATA <= REG_READ_ZERO;
        end
    end
    // Reference values built independently of the datapath, for checking only
    logic [2*FIX_W-1:0] rot_cat;
    logic [FIX_W-1:0] rot_ref, onehot_ref, place_mask_ref;
    logic oor_ref, src_sign, amt_pos, amt_far_right, amt_small_left;
    assign rot_cat = {fix_src, fix_src} << amount[4:0];
    assign rot_ref = rot_cat[2*FIX_W-1:FIX_W];
    assign onehot_ref = 32'h0000_0001 << amount[4:0];
    assign oor_ref = (amount < 32'sh0000_0000) || (amount > 32'sh0000_001F);
    assign place_mask_ref = len_mask << dep_pos;
    assign src_sign = fix_src[FIX_W-1];
    assign amt_pos = amount > 32'sh0000_0000;
    assign amt_far_right = amount <= -32'sh0000_0020;
    assign amt_small_left = amt_pos && (amount < 32'sh0000_0020);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_issue(shu_op_t o);
        issue && op == o;
    endsequence
    sequence s_done_write;
        FLAG_UPDATE && RESULT_WRITE;
    endsequence
    property p_ext_zero;
        issue |=> RESULT_WORD[EXT_W-1:0] == EXT_CLEARED && FLAG_UPDATE;
    endproperty
    a_ext_zero: assert property (p_ext_zero) else $error("extension byte not zero");
    property p_shift_or;
        s_issue(OP_ARITH_SHIFT_OR) ##0 amt_small_left |=> s_done_write ##0
            RESULT_WORD[WORD_W-1:FIX_LSB] == ($past(fix_dst) | ($past(fix_src) << $past(amount[4:0])));
    endproperty
    a_shift_or: assert property (p_shift_or) else $error("shift-or result wrong");
    property p_shift_ovf;
        s_issue(OP_ARITH_SHIFT_OR) |=> SHIFTER_OVERFLOW_FLAG == $past(amt_pos);
    endproperty
    a_shift_ovf: assert property (p_shift_ovf) else $error("shift overflow flag wrong");
    property p_shift_offscale;
        s_issue(OP_ARITH_SHIFT_OR) ##0 amt_far_right |=>
            RESULT_WORD[WORD_W-1:FIX_LSB] == ($past(fix_dst) | {FIX_W{$past(src_sign)}});
    endproperty
    a_shift_offscale: assert property (p_shift_offscale) else $error("off-scale right wrong");
    property p_sign_clear;
        FLAG_UPDATE |-> !SHIFTER_SIGN_FLAG;
    endproperty
    a_sign_clear: assert property (p_sign_clear) else $error("sign flag not cleared");
    property p_rotate;
        s_issue(OP_ROTATE) |=> s_done_write ##0 !SHIFTER_OVERFLOW_FLAG &&
            RESULT_WORD[WORD_W-1:FIX_LSB] == $past(rot_ref);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate result or flag wrong");
    property p_bit_range;
        issue && (op == OP_BIT_CLEAR || op == OP_BIT_SET || op == OP_BIT_TOGGLE) && oor_ref
            |=> RESULT_WORD[WORD_W-1:FIX_LSB] == $past(fix_src);
    endproperty
    a_bit_range: assert property (p_bit_range) else $error("out-of-range bit op changed data");
    property p_bit_clear;
        s_issue(OP_BIT_CLEAR) ##0 !oor_ref |=>
            RESULT_WORD[WORD_W-1:FIX_LSB] == ($past(fix_src) & ~$past(onehot_ref));
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");
    property p_bit_toggle;
        s_issue(OP_BIT_TOGGLE) ##0 !oor_ref |=>
            RESULT_WORD[WORD_W-1:FIX_LSB] == ($past(fix_src) ^ $past(onehot_ref));
    endproperty
    a_bit_toggle: assert property (p_bit_toggle) else $error("bit toggle wrong");
    property p_test;
        s_issue(OP_BIT_TEST) |=> !RESULT_WRITE && FLAG_UPDATE &&
            SHIFTER_ZERO_FLAG == ($past(oor_ref) || (($past(fix_src) & $past(onehot_ref)) == 0));
    endproperty
    a_test: assert property (p_test) else $error("bit test wrong");
    property p_dep_ovf;
        issue && (op == OP_FIELD_DEPOSIT || op == OP_FIELD_DEPOSIT_OR) |=>
            SHIFTER_OVERFLOW_FLAG == ($past(dep_len) + $past(dep_pos) > 7'h20);
    endproperty
    a_dep_ovf: assert property (p_dep_ovf) else $error("deposit overflow wrong");
    property p_dep_clear;
        s_issue(OP_FIELD_DEPOSIT) |=> (RESULT_WORD[WORD_W-1:FIX_LSB] & ~$past(place_mask_ref)) == 0;
    endproperty
    a_dep_clear: assert property (p_dep_clear) else $error("deposit left stray bits");
    property p_dep_or;
        s_issue(OP_FIELD_DEPOSIT_OR) |=> s_done_write ##0
            (RESULT_WORD[WORD_W-1:FIX_LSB] & $past(fix_dst)) == $past(fix_dst);
    endproperty
    a_dep_or: assert property (p_dep_or) else $error("deposit-or lost old bits");

endmodule
`default_nettype wire

/* File: logic/shu_pkg.sv */
// Constants, field layouts and operation codes of the shifter bit-field unit
package shu_pkg;

    // Register-file word layout
    localparam int unsigned WORD_W = 40;
    localparam int unsigned FIX_W = 32;
    localparam int unsigned EXT_W = 8;
    localparam int unsigned FIX_LSB = 8;
    localparam int unsigned IMM_W = 8;
    localparam int unsigned CTL6_W = 6;

    // Field controls inside the fixed-point field of the control operand
    localparam int unsigned CTL_POS_LSB = 0;
    localparam int unsigned CTL_LEN_LSB = 6;

    // Limits
    localparam logic signed [FIX_W-1:0] SHIFT_LIMIT = 32'sh0000_0020;
    localparam logic [CTL6_W:0] DEPOSIT_LIMIT = 7'h20;
    localparam logic [EXT_W-1:0] EXT_CLEARED = 8'h00;

    // Operations
    typedef enum logic [2:0] {
        OP_ARITH_SHIFT_OR = 3'h0,
        OP_ROTATE = 3'h1,
        OP_BIT_CLEAR = 3'h2,
        OP_BIT_SET = 3'h3,
        OP_BIT_TOGGLE = 3'h4,
        OP_BIT_TEST = 3'h5,
        OP_FIELD_DEPOSIT = 3'h6,
        OP_FIELD_DEPOSIT_OR = 3'h7
    } shu_op_t;

    typedef enum logic [1:0] {
        BIT_CLEAR = 2'h0,
        BIT_SET = 2'h1,
        BIT_TOGGLE = 2'h2,
        BIT_TEST = 2'h3
    } shu_bitmode_t;

    // Register port map
    localparam int unsigned REG_ADDR_W = 4;
    localparam logic [REG_ADDR_W-1:0] REG_CTRL_OFS = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS_OFS = 4'h4;
    localparam logic [REG_ADDR_W-1:0] REG_COUNT_OFS = 4'h8;
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int unsigned STATUS_ZERO_BIT = 0;
    localparam int unsigned STATUS_OVF_BIT = 1;
    localparam int unsigned STATUS_SIGN_BIT = 2;
    localparam int unsigned COUNT_W = 16;
    localparam logic [31:0] REG_READ_ZERO = 32'h0000_0000;

endpackage

/* File: logic/shu_barrel.sv */
// Arithmetic shifter and 32-bit rotator for the fixed-point field
`timescale 1ns/100ps
`default_nettype none
module shu_barrel
    import shu_pkg::*;
(
    input wire logic [FIX_W-1:0] data,
    input wire logic signed [FIX_W-1:0] amount,
    input wire logic rotate,
    output logic [FIX_W-1:0] result,
    output logic shifted_left
);

    always_comb
    begin
        logic [FIX_W-1:0] mag;
        logic [2*FIX_W-1:0] cat;
        mag = 32'h0000_0000;
        cat = {data, data} << amount[4:0];
        shifted_left = (amount > 32'sh0000_0000);
        if (rotate)
        begin
            // Low five bits are the amount modulo 32, so negatives wrap right
            result = cat[2*FIX_W-1:FIX_W];
        end
        else if (!amount[FIX_W-1])
        begin
            result = (amount >= SHIFT_LIMIT) ? 32'h0000_0000 : (data << amount[4:0]);
        end
        else
        begin
            mag = FIX_W'(-amount);
            if (mag >= FIX_W'(SHIFT_LIMIT))
            begin
                result = {FIX_W{data[FIX_W-1]}};
            end
            else
            begin
                result = FIX_W'($signed(data) >>> mag[4:0]);
            end
        end
    end

endmodule
`default_nettype wire

/* File: logic/shu_bitop.sv */
// Single-bit clear, set, toggle and test on the fixed-point field
`timescale 1ns/100ps
`default_nettype none
module shu_bitop
    import shu_pkg::*;
(
    input wire logic [FIX_W-1:0] data,
    input wire logic signed [FIX_W-1:0] position,
    input wire shu_bitmode_t mode,
    output logic [FIX_W-1:0] result,
    output logic tested_bit,
    output logic out_of_range,
    output logic above_range
);

    logic [FIX_W-1:0] onehot;

    always_comb
    begin
        out_of_range = (position[FIX_W-1:5] != 27'h000_0000);
        above_range = !position[FIX_W-1] && out_of_range;
        // An empty mask leaves every bit alone off the end of the field
        onehot = out_of_range ? 32'h0000_0000 : (32'h0000_0001 << position[4:0]);
        tested_bit = |(data & onehot);
        case (mode)
            BIT_CLEAR: result = data & ~onehot;
            BIT_SET: result = data | onehot;
            BIT_TOGGLE: result = data ^ onehot;
            default: result = data;
        endcase
    end

endmodule
`default_nettype wire

/* File: verif/shu_regfile_model.sv */
// Destination register model standing for the core register file
`timescale 1ns/100ps
`default_nettype none
module shu_regfile_model
    import shu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WORD_W-1:0] load_word,
    input wire logic result_write,
    input wire logic [WORD_W-1:0] result_word,
    output logic [WORD_W-1:0] dest_word
);
    logic [WORD_W-1:0] dest_q;

    // Preload wins over write-back so an operand can be staged while a result lands
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dest_q <= '0;
        else if (load)
            dest_q <= load_word;
        else if (result_write)
            dest_q <= result_word;
    end

    assign dest_word = dest_q;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking testbench of the shifter bit-field unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin samples_checked++; if ((sn) !== (ex)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end
module tb
    import shu_pkg::*;
;
    typedef struct packed {logic wr; logic [WORD_W-1:0] res; logic z; logic v;} shu_exp_t;

    logic clk, rst, op_valid, use_imm, ld, reg_wr, reg_rd, result_write, flag_update, zf, vf, sf;
    logic [2:0] op_code;
    logic [WORD_W-1:0] src, ctl, ld_val, dest, result_word, y;
    logic [WORD_W-1:0] last_res = '0;
    logic [IMM_W-1:0] imm;
    logic [CTL6_W-1:0] fpos, flen;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    shu_exp_t expq[$];
    shu_exp_t got;
    int n_fail = 0;
    int samples_checked = 0;
    int i, c, t;
    int bp[4] = '{0, 31, 32, -1};
    int sh[10] = '{127, -128, 1, 31, 32, -32, -31, 0, -1, 33};
    int dp[6] = '{13, 0, 63, 20, 21, 5};
    int dl[6] = '{14, 32, 63, 12, 12, 0};
    logic [WORD_W-1:0] srcs[2] = '{40'h80_0000_015A, 40'h00_0000_0133};

    shu_unit dut (.CLK(clk), .RST(rst), .OP_VALID(op_valid), .OP_CODE(op_code),
        .USE_IMM(use_imm), .SOURCE_REGISTER(src), .DESTINATION_REGISTER(dest),
        .CONTROL_REGISTER_OPERAND(ctl), .IMMEDIATE_SHIFT_AMOUNT(imm),
        .FIELD_POSITION_CONTROL(fpos), .FIELD_LENGTH_CONTROL(flen), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .RESULT_WORD(result_word), .RESULT_WRITE(result_write), .FLAG_UPDATE(flag_update),
        .SHIFTER_ZERO_FLAG(zf), .SHIFTER_OVERFLOW_FLAG(vf), .SHIFTER_SIGN_FLAG(sf));

    shu_regfile_model partner (.clk(clk), .rst(rst), .load(ld), .load_word(ld_val),
        .result_write(result_write), .result_word(result_word), .dest_word(dest));

    function automatic shu_exp_t model(input int c, input logic ui, input logic [39:0] s, d,
                                       input logic [39:0] y, input logic [7:0] im,
                                       input logic [5:0] bp, bl);
        logic signed [31:0] a;
        logic signed [31:0] fs;
        logic [31:0] r;
        logic [63:0] w;
        int p;
        int l;
        shu_exp_t e;
        fs = s[39:8];
        a = ui ? {{24{im[7]}}, im} : y[39:8];
        p = ui ? bp : y[13:8];
        l = ui ? bl : y[19:14];
        e.wr = 1'b1;
        e.v = 1'b0;
        if (c == 0)
        begin
            if (a > 31)
                r = 32'h0;
            else if (a >= 0)
                r = fs << a;
            else if (a < -31)
                r = {32{fs[31]}};
            else
                r = fs >>> (-a);
            e.v = a > 0;
            e.z = r == 32'h0;
            r = r | d[39:8];
        end
        else if (c == 1)
        begin
            w = {fs, fs} << a[4:0];
            r = w[63:32];
            e.z = r == 32'h0;
        end
        else if (c < 6)
        begin
            r = fs;
            if (a >= 0 && a < 32)
                r[a[4:0]] = (c == 3) | ((c == 4) & ~fs[a[4:0]]);
            e.v = a > 31;
            e.z = (c == 5) ? !(a >= 0 && a < 32 && fs[a[4:0]]) : r == 32'h0;
            e.wr = c != 5;
        end
        else
        begin
            w = l > 31 ? {32'h0, fs} : {32'h0, fs & ~(32'hFFFF_FFFF << l)};
            w = w << p;
            r = w[31:0];
            if (c == 7)
                r = r | d[39:8];
            e.v = l + p > 32;
            e.z = r == 32'h0;
        end
        e.res = {r, 8'h00};
        return e;
    endfunction

    // Ops that merge into the destination stage it one cycle ahead in the model
    task automatic op(input int c, input logic ui, input logic [39:0] s, d, y,
                      input int a, p, l, input logic acc);
        @(posedge clk);
        if (c == 0 || c == 7)
        begin
            op_valid <= 1'b0;
            ld <= 1'b1;
            ld_val <= d;
            @(posedge clk);
            ld <= 1'b0;
        end
        op_valid <= 1'b1;
        op_code <= 3'(c);
        use_imm <= ui;
        src <= s;
        ctl <= y;
        imm <= 8'(a);
        fpos <= 6'(p);
        flen <= 6'(l);
        if (acc)
            expq.push_back(model(c, ui, s, d, y, 8'(a), 6'(p), 6'(l)));
    endtask

    task automatic idle(input int n);
        @(posedge clk);
        op_valid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        op_valid <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        op_valid <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK("rdata", v, reg_rdata)
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Negedge sampling keeps the registered answer clear of the launching edge
    always @(negedge clk)
    begin
        if (flag_update === 1'b1 || result_write === 1'b1)
        begin
            if (expq.size() == 0)
            begin
                n_fail++;
                $display("[ERR] answer expected none seen %b", flag_update);
            end
            else
            begin
                got = expq.pop_front();
                `CHK("update", 1'b1, flag_update)
                `CHK("write", got.wr, result_write)
                if (got.wr)
                    `CHK("result", got.res, result_word)
                else
                    `CHK("held", last_res, result_word)
                if (got.wr)
                    last_res = got.res;
                `CHK("zero", got.z, zf)
                `CHK("ovf", got.v, vf)
                `CHK("sign", 1'b0, sf)
            end
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #400000;
        n_fail++;
        $display("[ERR] run expected done seen hung");
        give_verdict();
    end

    initial
    begin
        rst = 1'b1;
        op_valid = 1'b0;
        op_code = 3'h0;
        use_imm = 1'b0;
        ld = 1'b0;
        ld_val = '0;
        src = '0;
        ctl = '0;
        imm = '0;
        fpos = '0;
        flen = '0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        void'($urandom(83));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_reg(REG_CTRL_OFS, 32'h1);
        rd_reg(REG_STATUS_OFS, 32'h0);
        for (i = 0; i < 20; i++)
            op(i / 10, i[0], srcs[i[1]], 40'h12_3400_00FF, {32'(sh[i % 10]), 8'h00},
               sh[i % 10], 0, 0, 1'b1);
        for (i = 0; i < 64; i++)
            op(2 + i % 4, i[4], srcs[i[5]], 0, {32'(bp[i / 4 % 4]), 8'h00},
               bp[i / 4 % 4], 0, 0, 1'b1);
        for (i = 0; i < 24; i++)
            op(6 + i[0], i[1], srcs[i[2]], 40'h0F_00F0_0A55,
               {20'h0, 6'(dl[i / 4]), 6'(dp[i / 4]), 8'h00}, 0, dp[i / 4], dl[i / 4], 1'b1);
        for (i = 0; i < 60; i++)
        begin
            c = $urandom_range(0, 7);
            t = int'($urandom_range(0, 90)) - 45;
            y = c > 5 ? {$urandom, 8'h00} : {32'(t), 8'h00};
            op(c, 1'($urandom), {$urandom, 8'($urandom)}, {$urandom, 8'($urandom)}, y,
               $urandom_range(0, 255), $urandom_range(0, 63), $urandom_range(0, 63), 1'b1);
        end
        wr_reg(REG_COUNT_OFS, 32'h0);
        wr_reg(REG_CTRL_OFS, 32'h0);
        op(1, 1'b1, srcs[0], 0, 0, 4, 0, 0, 1'b0);
        wr_reg(REG_CTRL_OFS, 32'h1);
        wr_reg(4'hC, 32'hFFFF_FFFF);
        op(5, 1'b1, srcs[0], 0, 0, 40, 0, 0, 1'b1);
        idle(3);
        wr_reg(REG_STATUS_OFS, 32'hFFFF_FFFF);
        rd_reg(REG_STATUS_OFS, 32'h3);
        rd_reg(REG_COUNT_OFS, 32'h1);
        rd_reg(REG_CTRL_OFS, 32'h1);
        rd_reg(4'hC, 32'h0);
        idle(2);
        for (i = 0; i < 20 && expq.size() > 0; i++)
            @(posedge clk);
        if (expq.size() > 0)
        begin
            n_fail++;
            $display("[ERR] answers expected %0d seen fewer", expq.size());
        end
        give_verdict();
    end
endmodule
`default_nettype wire
